// File: hdl/rxflc_consts.vh
`ifndef RXFLC_CONSTS_VH
`define RXFLC_CONSTS_VH
// Bus address, seven bits
`define RXFLC_I2C_ADDR 7'h50
// Register offsets
`define RXFLC_OFS_FRAC_HI 8'hB3
`define RXFLC_OFS_FRAC_MID 8'hB4
`define RXFLC_OFS_FRAC_LO 8'hB5
`define RXFLC_OFS_THRESH1 8'hBC
`define RXFLC_OFS_CFG1 8'hBD
`define RXFLC_OFS_THRESH2 8'hBE
`define RXFLC_OFS_CFG2 8'hBF
`define RXFLC_OFS_SLICE1 8'hC0
`define RXFLC_OFS_SLICE2 8'hC1
`define RXFLC_OFS_LIMCFG 8'hC2
`define RXFLC_OFS_STATUS 8'hC3
// Per-channel threshold, signal loss and slice configuration fields
`define RXFLC_CFG_DAC_EN 0
`define RXFLC_CFG_POL 1
`define RXFLC_CFG_SL_EN 2
`define RXFLC_CFG_SL_SGN 3
`define RXFLC_CFG_HYST_LSB 4
`define RXFLC_CFG_HYST_MSB 6
`define RXFLC_CFG_PWR_OFF 7
// Limiter configuration fields
`define RXFLC_LIM_PREC 0
`define RXFLC_LIM_INPUT_CHANNEL_SELECT 1
`define RXFLC_LIM_DUAL_AMP_POWER 2
`define RXFLC_LIM_BW_OVR 3
`define RXFLC_LIM_BW_LSB 4
`define RXFLC_LIM_BW_MSB 6
// Status fields
`define RXFLC_ST_LOS1 0
`define RXFLC_ST_LOS2 1
`define RXFLC_ST_INWIN 2
// Reset values; hysteresis code 3 is the 2.5 dB default
`define RXFLC_CFG_RST 8'h30
`define RXFLC_THRESH_RST 8'h00
`define RXFLC_SLICE_RST 8'h00
`define RXFLC_LIM_RST 8'h00
`define RXFLC_FRAC_HI_RST 8'h00
`define RXFLC_FRAC_MID_RST 8'h00
`define RXFLC_FRAC_LO_RST 8'h01
// Frequency window, measurement length and hysteresis step
`define RXFLC_WINDOW_PPM 12'h3E8
`define RXFLC_PPM_SCALE 1000000
`define RXFLC_FWD_REF_TICKS 16'h0040
`define RXFLC_HYST_STEP 8'h02
`endif

// File: hdl/rxflc_top.v
// Notes on behaviour
// - Precedence bit picks pin or register channel
// - Bandwidth follows rate unless bus overrides; widest
// - Loss flag high when strength below threshold
// - Hysteresis default 2.5 dB, programmable 0.85 dB
// - Threshold from register converter when enabled
// - Polarity bit inverts channel loss output
// - Auto power-off on open pin, pin mode only
// - Slice offset applied only when enabled
// - Slice offset is sign plus 8-bit magnitude
// - Divided oscillator compared against reference window
// - Outside window: phase detector off, steer back
// - In-window output enables phase acquisition
// - Window supervision continues after lock
// - Fractional word is 22 bits wide
// - Both-on powers both amplifiers, one feeds recovery
// - Precedence bits default to pin control
// - Low interface pin selects pin mode
`timescale 1ns/10ps
`include "rxflc_consts.vh"
module rxflc_top #(
	parameter TW = 20,
	parameter [15:0] FWD_REF_TICKS = `RXFLC_FWD_REF_TICKS,
	parameter [7:0] HYST_STEP = `RXFLC_HYST_STEP
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Mode and serial bus pins
	input wire user_interface_select,
	input wire chip_select,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	// Channel selection and amplifiers
	input wire input_channel_select,
	input wire [2:0] rate_octave,
	output reg amp_power_ch1,
	output reg amp_power_ch2,
	output reg cdr_input_ch1,
	output reg [2:0] amp_bw_octave,
	// Signal strength and loss
	input wire [7:0] signal_strength_reading_ch1,
	input wire [7:0] signal_strength_reading_ch2,
	input wire [7:0] threshold_input_ch1,
	input wire [7:0] threshold_input_ch2,
	input wire thresh_pin_open_ch1,
	input wire thresh_pin_open_ch2,
	output reg signal_loss_flag_ch1,
	output reg signal_loss_flag_ch2,
	output reg los_det_enable_ch1,
	output reg los_det_enable_ch2,
	// Slice offset, sign in bit 8
	output reg [8:0] slice_offset_ch1,
	output reg [8:0] slice_offset_ch2,
	// Frequency window detector
	input wire ref_tick,
	input wire vco_tick,
	input wire [TW-1:0] fwd_target_count,
	output reg freq_window_ok,
	output reg phase_detector_enable,
	output reg vco_steer_up,
	output reg vco_steer_down,
	// Fractional synthesizer word
	output reg [21:0] frac_word
);
	localparam ST_IDLE = 7'h01;
	localparam ST_ADDR = 7'h02;
	localparam ST_ACK = 7'h04;
	localparam ST_REG = 7'h08;
	localparam ST_WDATA = 7'h10;
	localparam ST_RDATA = 7'h20;
	localparam ST_MACK = 7'h40;
	localparam [15:0] REF_LAST = FWD_REF_TICKS - 16'h0001;
	localparam [TW+11:0] PPM_DIV = `RXFLC_PPM_SCALE;
	reg [7:0] thresh1;
	reg [7:0] cfg1;
	reg [7:0] thresh2;
	reg [7:0] cfg2;
	reg [7:0] slice1;
	reg [7:0] slice2;
	reg [7:0] limcfg;
	reg [7:0] frac_hi;
	reg [7:0] frac_mid;
	reg [7:0] frac_lo;
	reg [2:0] status_s1;
	reg [2:0] status_s2;
	reg [6:0] state;
	reg scl_s;
	reg sda_s;
	reg scl_p;
	reg sda_p;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg [7:0] tx;
	reg [7:0] ptr;
	reg rw;
	reg got_ptr;
	reg more;
	reg los_raw1;
	reg los_raw2;
	reg [15:0] ref_cnt;
	reg [TW-1:0] vco_cnt;
	wire bus_mode = user_interface_select;
	wire bus_live = bus_mode & chip_select;
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
	wire bus_stop = scl_s & scl_p & ~sda_p & sda_s;
	// Pin mode sees power-on defaults only
	wire [7:0] ecfg1 = bus_mode ? cfg1 : `RXFLC_CFG_RST;
	wire [7:0] ecfg2 = bus_mode ? cfg2 : `RXFLC_CFG_RST;
	wire [7:0] elim = bus_mode ? limcfg : `RXFLC_LIM_RST;
	wire sel_ch1 = elim[`RXFLC_LIM_PREC] ?
		elim[`RXFLC_LIM_INPUT_CHANNEL_SELECT] : input_channel_select;
	wire both_on = elim[`RXFLC_LIM_DUAL_AMP_POWER];
	wire [7:0] thr1 = ecfg1[`RXFLC_CFG_DAC_EN] ?
		thresh1 : threshold_input_ch1;
	wire [7:0] thr2 = ecfg2[`RXFLC_CFG_DAC_EN] ?
		thresh2 : threshold_input_ch2;
	wire off1 = bus_mode ? ecfg1[`RXFLC_CFG_PWR_OFF] :
		thresh_pin_open_ch1;
	wire off2 = bus_mode ? ecfg2[`RXFLC_CFG_PWR_OFF] :
		thresh_pin_open_ch2;
	wire [TW-1:0] vco_now = vco_cnt + {{(TW-1){1'b0}}, vco_tick};
	wire [TW-1:0] tol = win_tol(fwd_target_count);
	wire [TW:0] lo_lim = {1'b0, fwd_target_count} - {1'b0, tol};
	wire [TW:0] hi_lim = {1'b0, fwd_target_count} + {1'b0, tol};
	wire too_slow = {1'b0, vco_now} < lo_lim;
	wire too_fast = {1'b0, vco_now} > hi_lim;
	wire [7:0] rd_byte = reg_read(ptr);
	// Once lost, strength must clear threshold plus margin to recover
	function los_calc;
		input prev;
		input [7:0] signal_strength_reading;
		input [7:0] thr;
		input [2:0] hy;
		reg [10:0] up;
		begin
			up = {3'h0, thr} + {8'h00, hy} * {3'h0, HYST_STEP};
			los_calc = prev ? ({3'h0, signal_strength_reading} < up) : (signal_strength_reading < thr);
		end
	endfunction
	function [TW-1:0] win_tol;
		input [TW-1:0] t;
		reg [TW+11:0] p;
		begin
			p = {12'h000, t} * {{TW{1'b0}}, `RXFLC_WINDOW_PPM};
			p = p / PPM_DIV;
			win_tol = p[TW-1:0];
		end
	endfunction
	function [7:0] reg_read;
		input [7:0] a;
		begin
			case (a)
			`RXFLC_OFS_FRAC_HI: reg_read = frac_hi;
			`RXFLC_OFS_FRAC_MID: reg_read = frac_mid;
			`RXFLC_OFS_FRAC_LO: reg_read = frac_lo;
			`RXFLC_OFS_THRESH1: reg_read = thresh1;
			`RXFLC_OFS_CFG1: reg_read = cfg1;
			`RXFLC_OFS_THRESH2: reg_read = thresh2;
			`RXFLC_OFS_CFG2: reg_read = cfg2;
			`RXFLC_OFS_SLICE1: reg_read = slice1;
			`RXFLC_OFS_SLICE2: reg_read = slice2;
			`RXFLC_OFS_LIMCFG: reg_read = limcfg;
			`RXFLC_OFS_STATUS: reg_read = {5'h00, status_s2};
			default: reg_read = 8'h00;
			endcase
		end
	endfunction
	// Serial bus slave and register file
	always @(posedge core_clk) begin
		if (rst) begin
			scl_s <= 1'b1;
			sda_s <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			got_ptr <= 1'b0;
			more <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			thresh1 <= `RXFLC_THRESH_RST;
			thresh2 <= `RXFLC_THRESH_RST;
			cfg1 <= `RXFLC_CFG_RST;
			cfg2 <= `RXFLC_CFG_RST;
			slice1 <= `RXFLC_SLICE_RST;
			slice2 <= `RXFLC_SLICE_RST;
			limcfg <= `RXFLC_LIM_RST;
			frac_hi <= `RXFLC_FRAC_HI_RST;
			frac_mid <= `RXFLC_FRAC_MID_RST;
			frac_lo <= `RXFLC_FRAC_LO_RST;
		end else begin
			scl_s <= scl_in;
			sda_s <= sda_in;
			scl_p <= scl_s;
			sda_p <= sda_s;
			if (!bus_live) begin
				state <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (bus_start) begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				got_ptr <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (bus_stop) begin
				state <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (state)
				ST_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						sda_oe_n <= 1'b0;
						state <= ST_ACK;
						if (state == ST_ADDR) begin
							rw <= shift[0];
							if (shift[7:1] != `RXFLC_I2C_ADDR) begin
								sda_oe_n <= 1'b1;
								state <= ST_IDLE;
							end
						end else if (state == ST_REG) begin
							ptr <= shift;
							got_ptr <= 1'b1;
						end else begin
							ptr <= ptr + 8'h01;
							case (ptr)
							`RXFLC_OFS_FRAC_HI: frac_hi <= {2'b00, shift[5:0]};
							`RXFLC_OFS_FRAC_MID: frac_mid <= shift;
							`RXFLC_OFS_FRAC_LO: frac_lo <= shift;
							`RXFLC_OFS_THRESH1: thresh1 <= shift;
							`RXFLC_OFS_CFG1: cfg1 <= shift;
							`RXFLC_OFS_THRESH2: thresh2 <= shift;
							`RXFLC_OFS_CFG2: cfg2 <= shift;
							`RXFLC_OFS_SLICE1: slice1 <= shift;
							`RXFLC_OFS_SLICE2: slice2 <= shift;
							`RXFLC_OFS_LIMCFG: limcfg <= shift;
							default: ;
							endcase
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (rw) begin
							tx <= rd_byte;
							sda_oe_n <= rd_byte[7];
							state <= ST_RDATA;
						end else begin
							sda_oe_n <= 1'b1;
							state <= got_ptr ? ST_WDATA : ST_REG;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							sda_oe_n <= 1'b1;
							ptr <= ptr + 8'h01;
							state <= ST_MACK;
						end else begin
							sda_oe_n <= tx[6];
							tx <= {tx[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						more <= ~sda_s;
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (more) begin
							tx <= rd_byte;
							sda_oe_n <= rd_byte[7];
							state <= ST_RDATA;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end
	// Channel, amplifier, signal loss and slice outputs
	always @(posedge core_clk) begin
		if (rst) begin
			amp_power_ch1 <= 1'b0;
			amp_power_ch2 <= 1'b0;
			cdr_input_ch1 <= 1'b0;
			amp_bw_octave <= 3'h0;
			los_raw1 <= 1'b0;
			los_raw2 <= 1'b0;
			signal_loss_flag_ch1 <= 1'b0;
			signal_loss_flag_ch2 <= 1'b0;
			los_det_enable_ch1 <= 1'b0;
			los_det_enable_ch2 <= 1'b0;
			slice_offset_ch1 <= 9'h000;
			slice_offset_ch2 <= 9'h000;
			status_s1 <= 3'h0;
			status_s2 <= 3'h0;
			frac_word <= 22'h000001;
		end else begin
			cdr_input_ch1 <= sel_ch1;
			amp_power_ch1 <= sel_ch1 | both_on;
			amp_power_ch2 <= ~sel_ch1 | both_on;
			amp_bw_octave <= elim[`RXFLC_LIM_BW_OVR] ?
				elim[`RXFLC_LIM_BW_MSB:`RXFLC_LIM_BW_LSB] : rate_octave;
			los_det_enable_ch1 <= ~off1;
			los_det_enable_ch2 <= ~off2;
			los_raw1 <= ~off1 & los_calc(los_raw1, signal_strength_reading_ch1, thr1,
				ecfg1[`RXFLC_CFG_HYST_MSB:`RXFLC_CFG_HYST_LSB]);
			los_raw2 <= ~off2 & los_calc(los_raw2, signal_strength_reading_ch2, thr2,
				ecfg2[`RXFLC_CFG_HYST_MSB:`RXFLC_CFG_HYST_LSB]);
			signal_loss_flag_ch1 <= los_raw1 ^ ecfg1[`RXFLC_CFG_POL];
			signal_loss_flag_ch2 <= los_raw2 ^ ecfg2[`RXFLC_CFG_POL];
			slice_offset_ch1 <= ecfg1[`RXFLC_CFG_SL_EN] ?
				{ecfg1[`RXFLC_CFG_SL_SGN], slice1} : 9'h000;
			slice_offset_ch2 <= ecfg2[`RXFLC_CFG_SL_EN] ?
				{ecfg2[`RXFLC_CFG_SL_SGN], slice2} : 9'h000;
			status_s1 <= {freq_window_ok, los_raw2, los_raw1};
			status_s2 <= status_s1;
			frac_word <= {frac_hi[5:0], frac_mid, frac_lo};
		end
	end
	// Window detector judges oscillator ticks over each reference run
	always @(posedge core_clk) begin
		if (rst) begin
			ref_cnt <= 16'h0000;
			vco_cnt <= {TW{1'b0}};
			freq_window_ok <= 1'b0;
			phase_detector_enable <= 1'b0;
			vco_steer_up <= 1'b0;
			vco_steer_down <= 1'b0;
		end else if (ref_tick && ref_cnt == REF_LAST) begin
			ref_cnt <= 16'h0000;
			vco_cnt <= {TW{1'b0}};
			freq_window_ok <= ~too_slow & ~too_fast;
			phase_detector_enable <= ~too_slow & ~too_fast;
			vco_steer_up <= too_slow;
			vco_steer_down <= too_fast;
		end else begin
			vco_cnt <= vco_now;
			if (ref_tick) begin
				ref_cnt <= ref_cnt + 16'h0001;
			end
		end
	end
endmodule

// File: tb/rxflc_assertions.sv
`timescale 1ns/10ps
module rxflc_assertions (
	// Clock and reset
	input logic core_clk,
	input logic rst,
	// Mode and bus
	input logic user_interface_select,
	input logic chip_select,
	input logic sda_oe_n,
	// Channel selection
	input logic input_channel_select,
	input logic amp_power_ch1,
	input logic amp_power_ch2,
	input logic cdr_input_ch1,
	input logic [2:0] amp_bw_octave,
	// Signal loss and slice
	input logic thresh_pin_open_ch1,
	input logic los_det_enable_ch1,
	input logic signal_loss_flag_ch1,
	input logic [8:0] slice_offset_ch1,
	// Window detector
	input logic ref_tick,
	input logic freq_window_ok,
	input logic phase_detector_enable,
	input logic vco_steer_up,
	input logic vco_steer_down,
	input logic [21:0] frac_word
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire pin_mode = !user_interface_select;
	a_detector_gated: assert property (
		phase_detector_enable == freq_window_ok)
		else $error("detector enable differs from window flag");
	a_steer_outside: assert property (
		freq_window_ok |-> !vco_steer_up && !vco_steer_down)
		else $error("steering while in window");
	a_steer_single: assert property (
		!(vco_steer_up && vco_steer_down))
		else $error("steering both ways");
	a_window_on_tick: assert property (
		$changed(freq_window_ok) |-> $past(ref_tick))
		else $error("window flag moved without reference tick");
	a_pin_channel: assert property (
		(pin_mode && $stable(input_channel_select)) [*6] |->
		cdr_input_ch1 == input_channel_select &&
		amp_power_ch1 == input_channel_select &&
		amp_power_ch2 != input_channel_select)
		else $error("pin mode channel selection wrong");
	a_pin_auto_off: assert property (
		(pin_mode && thresh_pin_open_ch1) [*6] |->
		!los_det_enable_ch1 && !signal_loss_flag_ch1)
		else $error("open threshold pin left detection on");
	a_bus_ignored: assert property (
		(!chip_select || pin_mode) [*6] |-> sda_oe_n)
		else $error("data line driven while bus ignored");
	a_reset_state: assert property (
		$fell(rst) |-> amp_bw_octave == 3'h0 &&
		frac_word == 22'h000001 && slice_offset_ch1 == 9'h000)
		else $error("wrong state after reset");
	c_in_window: cover property (freq_window_ok);
	c_steer_up: cover property (vco_steer_up);
	c_both_on: cover property (amp_power_ch1 && amp_power_ch2);
endmodule
bind rxflc_top rxflc_assertions u_chk (.core_clk, .rst,
	.user_interface_select, .chip_select, .sda_oe_n,
	.input_channel_select, .amp_power_ch1, .amp_power_ch2,
	.cdr_input_ch1, .amp_bw_octave, .thresh_pin_open_ch1,
	.los_det_enable_ch1, .signal_loss_flag_ch1, .slice_offset_ch1,
	.ref_tick, .freq_window_ok, .phase_detector_enable,
	.vco_steer_up, .vco_steer_down, .frac_word);

// File: tb/rxflc_fe_model.sv
`timescale 1ns/10ps
module rxflc_fe_model #(
	parameter REF_P = 250
) (
	// Clock and control
	input wire core_clk,
	input wire vco_en,
	// Tick outputs
	output reg ref_tick = 1'b0,
	output reg vco_tick = 1'b0
);
	integer cnt = 0;
	// One divided oscillator edge per cycle while running
	always @(negedge core_clk) begin
		cnt <= (cnt == REF_P - 1) ? 0 : cnt + 1;
		ref_tick <= (cnt == REF_P - 1);
		vco_tick <= vco_en;
	end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam REF = 250;
	wire sda_out, sda_oe_n, amp_power_ch1, amp_power_ch2, cdr_input_ch1;
	wire signal_loss_flag_ch1, signal_loss_flag_ch2, los_det_enable_ch1;
	wire los_det_enable_ch2, freq_window_ok, phase_detector_enable;
	wire vco_steer_up, vco_steer_down, ref_tick, vco_tick;
	wire [2:0] amp_bw_octave;
	wire [8:0] slice_offset_ch1, slice_offset_ch2;
	wire [21:0] frac_word;
	reg core_clk = 1'b0, rst = 1'b1, user_interface_select = 1'b0;
	reg chip_select = 1'b1, scl_in = 1'b1, sda_m = 1'b1, vco_en = 1'b1;
	reg input_channel_select = 1'b0, thresh_pin_open_ch1 = 1'b0;
	reg thresh_pin_open_ch2 = 1'b0, s;
	reg [2:0] rate_octave = 3'h0;
	reg [7:0] signal_strength_reading_ch1 = 8'hFF, signal_strength_reading_ch2 = 8'hFF;
	reg [7:0] threshold_input_ch1 = 8'h20, threshold_input_ch2 = 8'h90;
	reg [19:0] fwd_target_count = 20'h003E8;
	reg [15:0] rdv;
	integer errors = 0, n_tests = 0, seed = 97, i, j, p, h, r1, r2, t;
	int tg [6] = '{1000, 1002, 1001, 998, 1000, 1000};
	// Open-drain data line with pull-up
	wire sda_in = sda_m & (sda_oe_n !== 1'b0);
	rxflc_top #(.FWD_REF_TICKS(16'h0004)) u_dut (.core_clk, .rst,
		.user_interface_select, .chip_select, .scl_in, .sda_in, .sda_out,
		.sda_oe_n, .input_channel_select, .rate_octave, .amp_power_ch1,
		.amp_power_ch2, .cdr_input_ch1, .amp_bw_octave, .signal_strength_reading_ch1,
		.signal_strength_reading_ch2, .threshold_input_ch1, .threshold_input_ch2,
		.thresh_pin_open_ch1, .thresh_pin_open_ch2, .signal_loss_flag_ch1,
		.signal_loss_flag_ch2, .los_det_enable_ch1, .los_det_enable_ch2,
		.slice_offset_ch1, .slice_offset_ch2, .ref_tick, .vco_tick,
		.fwd_target_count, .freq_window_ok, .phase_detector_enable,
		.vco_steer_up, .vco_steer_down, .frac_word);
	rxflc_fe_model #(.REF_P(REF)) u_fe (.core_clk, .vco_en, .ref_tick,
		.vco_tick);
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task cyc(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("ERROR %0s exp %0h seen %0h", nm, exp, seen);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", n_tests, errors);
			if (errors == 0 && n_tests > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Data changes only while the bus clock is low
	task sbit(input b);
		begin
			sda_m = b;
			cyc(6);
			scl_in = 1'b1;
			cyc(4);
			s = sda_in;
			cyc(4);
			scl_in = 1'b0;
			cyc(2);
		end
	endtask
	task sbyte(input [7:0] d, input ea);
		integer k;
		begin
			for (k = 7; k >= 0; k = k - 1)
				sbit(d[k]);
			sbit(1'b1);
			check("ack", s, !ea);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d, input ea);
		begin
			sda_m = 1'b0;
			cyc(6);
			scl_in = 1'b0;
			cyc(2);
			sbyte(8'hA0, ea);
			sbyte(a, ea);
			sbyte(d, ea);
			sda_m = 1'b0;
			cyc(6);
			scl_in = 1'b1;
			cyc(6);
			sda_m = 1'b1;
			cyc(6);
		end
	endtask
	// Pointer write, repeated start, two bytes read with auto-increment
	task rd(input [7:0] a, output [15:0] d);
		integer k;
		begin
			sda_m = 1'b0;
			cyc(6);
			scl_in = 1'b0;
			cyc(2);
			sbyte(8'hA0, 1'b1);
			sbyte(a, 1'b1);
			sda_m = 1'b1;
			cyc(6);
			scl_in = 1'b1;
			cyc(6);
			sda_m = 1'b0;
			cyc(6);
			scl_in = 1'b0;
			cyc(2);
			sbyte(8'hA1, 1'b1);
			for (k = 15; k >= 0; k = k - 1) begin
				sbit(1'b1);
				d[k] = s;
				if (k == 8)
					sbit(1'b0);
			end
			sbit(1'b1);
			sda_m = 1'b0;
			cyc(6);
			scl_in = 1'b1;
			cyc(6);
			sda_m = 1'b1;
			cyc(6);
		end
	endtask
	initial begin
		cyc(100000);
		errors = errors + 1;
		print_verdict;
	end
	initial begin
		cyc(16);
		rst = 1'b0;
		cyc(8);
		thresh_pin_open_ch1 = 1'b1;
		thresh_pin_open_ch2 = 1'b1;
		cyc(8);
		check("det1", los_det_enable_ch1, 0);
		check("det2", los_det_enable_ch2, 0);
		thresh_pin_open_ch1 = 1'b0;
		thresh_pin_open_ch2 = 1'b0;
		user_interface_select = 1'b1;
		for (i = 0; i < 16; i = i + 1) begin
			input_channel_select = i[3];
			wr(8'hC2, {5'h0, i[2:0]}, 1'b1);
			t = i[0] ? i[1] : i[3];
			check("cdr", cdr_input_ch1, t);
			check("amp1", amp_power_ch1, t | i[2]);
			check("amp2", amp_power_ch2, !t | i[2]);
		end
		chip_select = 1'b0;
		wr(8'hC2, 8'h01, 1'b0);
		check("cdr", cdr_input_ch1, 1);
		chip_select = 1'b1;
		thresh_pin_open_ch1 = 1'b1;
		thresh_pin_open_ch2 = 1'b1;
		cyc(6);
		check("det1", los_det_enable_ch1, 1);
		check("det2", los_det_enable_ch2, 1);
		thresh_pin_open_ch1 = 1'b0;
		thresh_pin_open_ch2 = 1'b0;
		for (j = 0; j < 2; j = j + 1) begin
			t = $random(seed);
			rate_octave = t[2:0];
			wr(8'hC2, {4'h5, j[0], 3'h0}, 1'b1);
			check("bw", amp_bw_octave, j ? 5 : rate_octave);
		end
		t = $random(seed) | 1;
		wr(8'hB3, t[23:16], 1'b1);
		wr(8'hB4, t[15:8], 1'b1);
		wr(8'hB5, t[7:0], 1'b1);
		check("frac", frac_word, t[21:0]);
		for (p = 0; p < 2; p = p + 1) begin
			h = $random(seed) & 7;
			wr(8'hBC, 8'h80, 1'b1);
			wr(8'hBD, {1'b0, h[2:0], 1'b1, p[0], p[0], 1'b1}, 1'b1);
			wr(8'hC0, p[0] ? 8'hA6 : 8'hA5, 1'b1);
			check("slice1", slice_offset_ch1, p ? 9'h1A6 : 0);
			check("slice2", slice_offset_ch2, 0);
			signal_strength_reading_ch1 = 8'hFF;
			signal_strength_reading_ch2 = 8'hFF;
			cyc(6);
			r1 = 0;
			r2 = 0;
			for (i = 0; i < 24; i = i + 1) begin
				t = $random(seed);
				signal_strength_reading_ch1 = 8'h70 + {2'b00, t[5:0]};
				signal_strength_reading_ch2 = signal_strength_reading_ch1 + 8'h10;
				if (signal_strength_reading_ch1 < 8'h80) r1 = 1;
				else if (signal_strength_reading_ch1 >= 8'h80 + 2 * h) r1 = 0;
				if (signal_strength_reading_ch2 < 8'h90) r2 = 1;
				else if (signal_strength_reading_ch2 >= 8'h96) r2 = 0;
				cyc(4);
				check("los1", signal_loss_flag_ch1, r1 ^ p);
				check("los2", signal_loss_flag_ch2, r2);
			end
		end
		for (i = 0; i < 6; i = i + 1) begin
			t = tg[i];
			fwd_target_count = t[19:0];
			vco_en = i != 5;
			cyc(2100);
			j = vco_en ? 4 * REF : 0;
			h = t * 1000 / 1000000;
			p = j >= t - h && j <= t + h;
			check("win", freq_window_ok, p);
			check("up", vco_steer_up, j < t - h);
			check("down", vco_steer_down, j > t + h);
			rd(8'hC2, rdv);
			check("limrd", rdv[15:8], 8'h58);
			check("status", rdv[7:0], p * 4 + r2 * 2 + r1);
			check("sdao", sda_out, 0);
		end
		print_verdict;
	end
endmodule
